// ### dv/ddr2_dev_model.sv
/* Write-side model of the SDRAM.
   Watches host pins in the mclk domain; keeps captured words. */
`timescale 1ns/1ps
`include "ddr2_wr_host_regs.vh"
module ddr2_dev_model #(
   parameter BL = 8
) (
   input  wire       mclk,
   input  wire       ck,
   input  wire       cs_n,
   input  wire       ras_n,
   input  wire       cas_n,
   input  wire       we_n,
   input  wire [2:0] ba,
   input  wire [13:0] addr,
   input  wire [7:0] dq_o,
   input  wire       dqs_o,
   input  wire       dqs_oe,
   output wire [7:0] dq_i,
   output wire       dqs_i
);
   reg       ck_q = 1'b0;
   reg       dqs_q = 1'b0;
   reg       tog_q = 1'b0;
   reg [7:0] open_q = 8'h00;
   int       left = 0;
   int       got_n = 0;
   logic [7:0] got [0:255];
   wire wr = ck && !ck_q && {cs_n, ras_n, cas_n, we_n} == `PIN_WRITE;
   wire cap = dqs_oe && dqs_o != dqs_q && left > 0;
   // Released lines toggle
   assign dq_i = {8{tog_q}};
   assign dqs_i = tog_q;
   always @(posedge mclk) begin
      ck_q <= ck;
      dqs_q <= dqs_o;
      tog_q <= !tog_q;
      left <= (wr ? ((left > `TRUNC_LEN ? `TRUNC_LEN : left) + BL) : left) - (cap ? 1 : 0);
      if (cap) begin
         got[got_n] <= dq_o;
         got_n <= got_n + 1;
      end
      if (wr) open_q[ba] <= !addr[`A10_BIT];
   end
endmodule

// ### dv/ddr2_wr_host_chk.sv
/* Pin checker for the DDR2 write host.
   Bound to ddr2_wr_host; sees its ports only. */
`timescale 1ns/1ps
`include "ddr2_wr_host_regs.vh"
module ddr2_wr_host_chk #(
   parameter CL = 3,
   parameter BL = 8
) (
   input wire        mclk,
   input wire        sys_rst,
   input wire        req_ready,
   input wire [2:0]  mr_wr_field,
   input wire        ck,
   input wire        cs_n,
   input wire        ras_n,
   input wire        cas_n,
   input wire        we_n,
   input wire [2:0]  ba,
   input wire [13:0] addr,
   input wire [7:0]  dq_o,
   input wire        dqs_o,
   input wire        dqs_oe
);
   localparam int WTR_MIN = CL - 1 + BL / 2 + `WTR_CK;
   localparam int PRE_MIN = CL - 1 + BL / 2 + `WR_CK;
   wire [3:0] pins = {cs_n, ras_n, cas_n, we_n};
   reg        ck_q;
   reg [7:0]  gap_q;
   reg [2:0]  wbank_q;
   wire       smp = ck && !ck_q;
   always @(posedge mclk) begin
      ck_q <= ck;
      if (sys_rst) begin
         gap_q <= 8'hff;
         wbank_q <= 3'h0;
      end else if (smp && pins == `PIN_WRITE) begin
         gap_q <= 8'h01;
         wbank_q <= ba;
      end else if (smp && gap_q != 8'hff) begin
         gap_q <= gap_q + 8'h01;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_preamble_low: assert property ($rose(dqs_oe) |-> !dqs_o [*2])
      else $error("strobe not low in preamble");
   a_postamble_low: assert property ($fell(dqs_oe) |-> !$past(dqs_o) && !$past(dqs_o, 2))
      else $error("strobe not low in postamble");
   a_strobe_on_ck: assert property ($rose(dqs_o) |-> $rose(ck))
      else $error("strobe rise off clock rise");
   a_first_strobe: assert property (smp && pins == `PIN_WRITE && !dqs_oe |-> ##8 $rose(dqs_o))
      else $error("first strobe rise not at write latency");
   a_data_centred: assert property (dqs_oe && $changed(dqs_o) |-> $stable(dq_o))
      else $error("data moved with strobe edge");
   a_wtr_gap: assert property (smp && pins == `PIN_READ |-> gap_q >= WTR_MIN)
      else $error("read too soon after write");
   a_wr_spacing: assert property (smp && pins == `PIN_WRITE |-> gap_q == `INTR_GAP || gap_q >= BL / 2)
      else $error("write spacing illegal");
   a_wr_recovery: assert property (smp && pins == `PIN_PRE && (ba == wbank_q || addr[`A10_BIT])
      |-> gap_q >= PRE_MIN)
      else $error("precharge before write recovery");
   a_wr_field: assert property (mr_wr_field == `WR_CK)
      else $error("recovery field wrong");
   a_ready_slot: assert property (req_ready |-> ck && $past(ck))
      else $error("ready outside command slot");
   c_trunc: cover property (smp && pins == `PIN_WRITE && gap_q == `INTR_GAP);
   c_read: cover property (smp && pins == `PIN_READ);
   c_burst_end: cover property ($fell(dqs_oe));
endmodule
bind ddr2_wr_host ddr2_wr_host_chk #(.CL(CL), .BL(BL)) i_ddr2_wr_host_chk (.mclk(mclk),
   .sys_rst(sys_rst), .req_ready(req_ready), .mr_wr_field(mr_wr_field), .ck(ck), .cs_n(cs_n),
   .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_o(dq_o),
   .dqs_o(dqs_o), .dqs_oe(dqs_oe));

// ### dv/ddr2_wr_host_tb_top.sv
/* Testbench for ddr2_wr_host with the SDRAM model.
   Feeder keeps the data FIFO topped up with a counting pattern. */
`timescale 1ns/1ps
`include "ddr2_wr_host_regs.vh"
module ddr2_wr_host_tb_top;
   localparam int CL = 3;
   localparam int BL = 8;
   reg mclk, sys_rst, req_valid, req_ap, wdata_valid, ce;
   reg [2:0] req_cmd, req_bank;
   reg [13:0] req_addr;
   reg [7:0] wd_q, dq_o;
   reg [2:0] mr_wr_field, ba;
   reg [13:0] addr;
   reg ck, ck_n, dqs_o;
   wire req_ready, wdata_ready, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_i, dqs_oe;
   wire [7:0] dq_i;
   int error_cnt = 0, samples_checked = 0, cyc = 0, t0, t1, base = 0;
   ddr2_wr_host #(.CL(CL), .BL(BL), .DQ_W(8), .FIFO_DEPTH(16)) i_ddr2_wr_host (.mclk(mclk),
      .sys_rst(sys_rst), .ce(ce), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_bank(req_bank), .req_addr(req_addr), .req_ap(req_ap), .req_ready(req_ready),
      .wdata_valid(wdata_valid), .wdata(wd_q), .wdata_ready(wdata_ready),
      .mr_wr_field(mr_wr_field), .ck(ck), .ck_n(ck_n), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_i(dq_i), .dq_o(dq_o),
      .dq_oe(dq_oe), .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe));
   ddr2_dev_model #(.BL(BL)) i_ddr2_dev_model (.mclk(mclk), .ck(ck), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_o(dq_o),
      .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dq_i(dq_i), .dqs_i(dqs_i));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (sys_rst) wd_q <= 8'h00;
      else if (wdata_valid && wdata_ready) wd_q <= wd_q + 8'h01;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task issue(input [2:0] c, input [2:0] b, input a, output int t);
      req_cmd <= c;
      req_bank <= b;
      req_addr <= {11'h000, b};
      req_ap <= a;
      req_valid <= 1'b1;
      @(posedge mclk);
      while (req_ready !== 1'b1) @(posedge mclk);
      t = cyc;
      req_valid <= 1'b0;
      @(posedge mclk);
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (n < 400 && (n < 16 || i_ddr2_dev_model.left != 0 || dqs_oe !== 1'b0
             || wdata_ready !== 1'b0)) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task chk_words(input int n);
      int i;
      chk("count", n, i_ddr2_dev_model.got_n - base);
      for (i = base; i < i_ddr2_dev_model.got_n; i++) chk("word", i & 255, 32'(i_ddr2_dev_model.got[i]));
      base = i_ddr2_dev_model.got_n;
   endtask
   task t_reset;
      chk("pins", `PIN_NOP, {cs_n, ras_n, cas_n, we_n});
      chk("wr field", `WR_CK, mr_wr_field);
      wait_idle;
      chk("fifo fill", 16, wd_q);
      $display("t_reset done");
   endtask
   task t_single;
      issue(`CMD_WRITE, 3'h0, 1'b0, t0);
      wait_idle;
      chk_words(8);
      $display("t_single done");
   endtask
   task t_trunc;
      issue(`CMD_WRITE, 3'h1, 1'b0, t0);
      issue(`CMD_WRITE, 3'h2, 1'b1, t1);
      chk("trunc gap", 4 * `INTR_GAP, t1 - t0);
      wait_idle;
      chk_words(12);
      chk("a10 kept", 2'b01, {i_ddr2_dev_model.open_q[2], i_ddr2_dev_model.open_q[1]});
      $display("t_trunc done");
   endtask
   task t_wtr;
      issue(`CMD_WRITE, 3'h3, 1'b0, t0);
      issue(`CMD_READ, 3'h3, 1'b0, t1);
      chk("wtr gap", 4 * (CL - 1 + BL / 2 + `WTR_CK), t1 - t0);
      wait_idle;
      chk_words(8);
      $display("t_wtr done");
   endtask
   task t_pre;
      issue(`CMD_WRITE, 3'h4, 1'b0, t0);
      issue(`CMD_PRE, 3'h5, 1'b0, t1);
      chk("pre other gap", 4, t1 - t0);
      issue(`CMD_PRE, 3'h4, 1'b0, t1);
      chk("pre same gap", 4 * (CL - 1 + BL / 2 + `WR_CK), t1 - t0);
      issue(`CMD_PRE, 3'h0, 1'b1, t0);
      chk("pre all gap", 4, t0 - t1);
      issue(`CMD_ACT, 3'h4, 1'b0, t1);
      chk("act after pre gap", 4 * `RP_CK, t1 - t0);
      wait_idle;
      chk_words(8);
      $display("t_pre done");
   endtask
   task t_seamless;
      issue(`CMD_WRITE, 3'h6, 1'b1, t0);
      issue(`CMD_WRITE, 3'h7, 1'b0, t1);
      chk("seamless gap", 4 * BL / 2, t1 - t0);
      issue(`CMD_ACT, 3'h6, 1'b0, t1);
      chk("ap act gap", 4 * (CL - 1 + BL / 2 + `WR_CK + `RP_CK), t1 - t0);
      wait_idle;
      chk_words(16);
      $display("t_seamless done");
   endtask
   task t_freeze;
      logic ck0;
      ce <= 1'b0;
      @(posedge mclk);
      ck0 = ck;
      repeat (2) @(posedge mclk);
      chk("frozen ck", ck0, ck);
      ce <= 1'b1;
      @(posedge mclk);
      $display("t_freeze done");
   endtask
   initial begin
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req_cmd = `CMD_NOP;
      req_bank = 3'h0;
      req_addr = 14'h0000;
      req_ap = 1'b0;
      wdata_valid = 1'b1;
      ce = 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_reset;
      t_single;
      t_trunc;
      t_wtr;
      t_pre;
      t_seamless;
      t_freeze;
      report_and_stop;
   end
endmodule

// ### verilog/ddr2_wr_host.v
/*
 DDR2 write-path host: issues WRITE, READ, PRECHARGE and ACTIVATE under
 per-bank spacing counters, makes CK from mclk, drives DQS and DQ bursts
 from a write-data FIFO.
 Assumes the SDRAM was set up with the CL and BL given here, AL = 0, and
 that the requester opens and closes rows in a legal order.
*/
`timescale 1ns/1ps
`include "ddr2_wr_host_regs.vh"

module wr_data_fifo #(
   parameter W     = 8,
   parameter DEPTH = 8
) (
   input  wire                       clk,
   input  wire                       rst,
   input  wire                       ce,
   input  wire                       in_valid,
   input  wire [W-1:0]               in_data,
   output wire                       in_ready,
   output wire                       out_valid,
   output wire [W-1:0]               out_data,
   input  wire                       out_ready,
   output wire [$clog2(DEPTH):0]     level
);
   localparam AW = $clog2(DEPTH);
   reg  [W-1:0]  mem [0:DEPTH-1];
   reg  [AW:0]   wp_q;
   reg  [AW:0]   rp_q;
   wire          push;
   wire          pop;

   assign level     = wp_q - rp_q;
   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data  = mem[rp_q[AW-1:0]];
   assign push      = ce & in_valid & in_ready;
   assign pop       = ce & out_ready & out_valid;

   always @(posedge clk) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

// What this block does
// R1: Device latches first element on first DQS rise
// R2: DQS held low before and after data
// R3: First DQS rise WL clocks after WRITE
// R4: Later DQS rises aligned to CK edges
// R5: Data lines released once burst ends
// R6: Back-to-back writes BL/2 clocks apart, seamless
// R7: BL4 write bursts never interrupted
// R8: BL8 truncated only by WRITE, 4-boundary
// R9: Interrupting WRITE exactly two clocks later
// R10: No PRECHARGE to interrupted-write banks meanwhile
// R11: Precharge wait uses programmed burst length
// R12: Interrupting WRITE carries its own A10
// R13: READ waits max(2, tWTR) after write
// R14: Write-to-read counted after last data pair
// R15: Same-bank PRECHARGE waits write recovery
// R16: Other-bank PRECHARGE needs no write recovery
// R17: Auto-precharge write then other-bank READ spacing
// R18: Auto-precharge write then other-bank WRITE/PRE/ACT spacing
// R19: WR field is tWR over tCK, rounded up
// R20: A10 low means auto precharge off
// R21: Write latency is read latency minus one
// R22: Auto precharge closes row after burst
// R23: Per-bank counters hold commands until legal
module ddr2_wr_host #(
   parameter CL         = 3,
   parameter BL         = 8,
   parameter DQ_W       = 8,
   parameter FIFO_DEPTH = 8
) (
   input  wire               mclk,
   input  wire               sys_rst,
   input  wire               ce,
   input  wire               req_valid,
   input  wire [2:0]         req_cmd,
   input  wire [2:0]         req_bank,
   input  wire [13:0]        req_addr,
   input  wire               req_ap,
   output wire               req_ready,
   input  wire               wdata_valid,
   input  wire [DQ_W-1:0]    wdata,
   output wire               wdata_ready,
   output reg  [2:0]         mr_wr_field,
   output reg                ck,
   output reg                ck_n,
   output wire               cs_n,
   output wire               ras_n,
   output wire               cas_n,
   output wire               we_n,
   output reg  [2:0]         ba,
   output reg  [13:0]        addr,
   input  wire [DQ_W-1:0]    dq_i,
   output reg  [DQ_W-1:0]    dq_o,
   output wire               dq_oe,
   input  wire               dqs_i,
   output reg                dqs_o,
   output wire               dqs_oe
);
   localparam WL       = CL - 1;                                 // R21
   localparam SW       = WL + 2;
   localparam FCW      = $clog2(FIFO_DEPTH) + 1;
   localparam integer PRE_I  = WL + BL / 2 + `WR_CK - 1;           // R11
   localparam integer ACT_I  = WL + BL / 2 + `WR_CK + `RP_CK - 1;  // R22
   localparam integer RD_I   = WL + BL / 2 + `WTR_CK - 1;          // R13
   localparam integer RP_I   = `RP_CK - 1;
   localparam integer WLB_I  = 1 << WL;
   localparam [5:0]   PRE_LD = PRE_I[5:0];
   localparam [5:0]   ACT_LD = ACT_I[5:0];
   localparam [5:0]   RD_LD  = RD_I[5:0];
   localparam [5:0]   RP_LD  = RP_I[5:0];
   localparam integer GAP_N  = `INTR_GAP;
   localparam integer TRN_N  = `TRUNC_LEN;
   localparam [5:0]   HALF_BL = BL[6:1];
   localparam [5:0]   GAP_I  = GAP_N[5:0];
   localparam [3:0]   BL_E   = BL[3:0];
   localparam [7:0]   BL_W   = BL[7:0];
   localparam [7:0]   TRUNC_W = TRN_N[7:0];
   localparam [SW-1:0] WL_BIT = WLB_I[SW-1:0];
   localparam integer WRC_I  = `WR_CK;

   reg  [1:0]         ph_q;
   reg  [3:0]         pins_q;
   reg  [5:0]         wr_gap_q;
   reg                last_ap_q;
   reg  [5:0]         rd_wait_q;
   reg  [SW-1:0]      sched_q;
   reg  [3:0]         elem_q;
   reg                rise_q;
   reg                oe_q;
   reg  [7:0]         pend_q;
   wire [7:0]         pre_zero;
   wire [7:0]         act_zero;
   wire               slot;
   wire               fire;
   wire               intr_ok;
   wire               words_ok;
   wire               legal;
   wire               pop;
   wire               fifo_valid;
   wire [DQ_W-1:0]    fifo_data;
   wire [FCW-1:0]     fifo_level;
   wire [7:0]         have_w;
   reg  [13:0]        addr_d;

   function [3:0] cmd_pins;
      input [2:0] cmd;
      begin
         case (cmd)
            `CMD_WRITE: cmd_pins = `PIN_WRITE;
            `CMD_READ:  cmd_pins = `PIN_READ;
            `CMD_PRE:   cmd_pins = `PIN_PRE;
            `CMD_ACT:   cmd_pins = `PIN_ACT;
            default:    cmd_pins = `PIN_NOP;
         endcase
      end
   endfunction

   // One command slot per CK, pins change on CK fall so CK rise samples them
   assign slot  = ce & (ph_q == 2'h1);
   assign fire  = req_valid & req_ready;
   assign pop   = ce & ((ph_q == 2'h2) | (ph_q == 2'h0)) & (elem_q != 4'h0);

   // BL8 only, previous write without auto precharge, exactly two clocks
   assign intr_ok = (BL == 8) & ~last_ap_q & (wr_gap_q == GAP_I);  // R7 R8 R9
   assign have_w  = {{(8-FCW){1'b0}}, fifo_level} + (intr_ok ? TRUNC_W : 8'h00);
   assign words_ok = (have_w >= pend_q + BL_W);

   always @* begin
      addr_d = req_addr;
      if (req_cmd != `CMD_ACT) begin
         addr_d[`A10_BIT] = req_ap;                               // R12 R20
      end
   end

   assign legal =
      (req_cmd == `CMD_WRITE) ? (act_zero[req_bank] & words_ok &
                                 ((wr_gap_q >= HALF_BL) | intr_ok)) :   // R6 R18
      (req_cmd == `CMD_READ)  ? (act_zero[req_bank] &
                                 (rd_wait_q == 6'h00)) :          // R13 R14 R17
      (req_cmd == `CMD_PRE)   ? (req_ap ? (&pre_zero) :
                                 pre_zero[req_bank]) :            // R10 R15 R16
      (req_cmd == `CMD_ACT)   ? act_zero[req_bank] :              // R18 R22
      1'b1;
   assign req_ready = slot & legal;                                // R23

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : bank
         reg [5:0] pre_q;
         reg [5:0] act_q;
         wire hit = (req_bank == g);
         assign pre_zero[g] = (pre_q == 6'h00);
         assign act_zero[g] = (act_q == 6'h00);
         always @(posedge mclk) begin
            if (sys_rst) begin
               pre_q <= 6'h00;
               act_q <= 6'h00;
            end else if (slot) begin
               if (fire && req_cmd == `CMD_WRITE && hit) begin
                  pre_q <= PRE_LD;                                 // R11 R15
               end else if (pre_q != 6'h00) begin
                  pre_q <= pre_q - 6'h01;                          // R23
               end
               if (fire && req_cmd == `CMD_WRITE && hit && req_ap) begin
                  act_q <= ACT_LD;                                 // R22
               end else if (fire && req_cmd == `CMD_PRE && (hit || req_ap)) begin
                  act_q <= RP_LD;
               end else if (act_q != 6'h00) begin
                  act_q <= act_q - 6'h01;                          // R23
               end
            end
         end
      end
   endgenerate

   always @(posedge mclk) begin
      if (sys_rst) begin
         ph_q        <= 2'h2;                                      // Full CK high before slot
         ck          <= 1'b0;
         ck_n        <= 1'b1;
         pins_q      <= `PIN_NOP;
         ba          <= 3'h0;
         addr        <= 14'h0000;
         wr_gap_q    <= 6'h3f;
         last_ap_q   <= 1'b1;
         rd_wait_q   <= 6'h00;
         sched_q     <= {SW{1'b0}};
         mr_wr_field <= WRC_I[2:0];                                // R19
      end else if (ce) begin
         ph_q <= ph_q + 2'h1;
         ck   <= (ph_q == 2'h3) | (ph_q == 2'h0);
         ck_n <= ~((ph_q == 2'h3) | (ph_q == 2'h0));
         if (slot) begin
            pins_q  <= fire ? cmd_pins(req_cmd) : `PIN_NOP;
            sched_q <= {1'b0, sched_q[SW-1:1]} |
                       ((fire && req_cmd == `CMD_WRITE) ? WL_BIT : {SW{1'b0}});  // R3
            if (fire) begin
               ba   <= req_bank;
               addr <= addr_d;
            end
            if (fire && req_cmd == `CMD_WRITE) begin
               wr_gap_q  <= 6'h01;
               last_ap_q <= req_ap;
               rd_wait_q <= RD_LD;                                 // R14 R17
            end else begin
               if (wr_gap_q != 6'h3f) begin
                  wr_gap_q <= wr_gap_q + 6'h01;
               end
               if (rd_wait_q != 6'h00) begin
                  rd_wait_q <= rd_wait_q - 6'h01;
               end
            end
         end
      end
   end

   assign cs_n  = pins_q[3];
   assign ras_n = pins_q[2];
   assign cas_n = pins_q[1];
   assign we_n  = pins_q[0];

   // Burst engine: a new start reloads the count, which both chains and truncates
   always @(posedge mclk) begin
      if (sys_rst) begin
         elem_q <= 4'h0;
         rise_q <= 1'b0;
         oe_q   <= 1'b0;
         dqs_o  <= 1'b0;
         dq_o   <= {DQ_W{1'b0}};
         pend_q <= 8'h00;
      end else if (ce) begin
         if (pop) begin
            dq_o <= fifo_data;
         end
         if (slot && sched_q[1]) begin
            elem_q <= BL_E;                                        // R6 R8
            oe_q   <= 1'b1;                                        // R2
         end else if (pop) begin
            elem_q <= elem_q - 4'h1;
         end else if (ph_q == 2'h3 && elem_q == 4'h0) begin
            oe_q   <= 1'b0;                                        // R2 R5
         end
         if (ph_q == 2'h2) begin
            rise_q <= pop;
         end else if (ph_q == 2'h1) begin
            rise_q <= 1'b0;
         end
         dqs_o  <= ((ph_q == 2'h3) | (ph_q == 2'h0)) & rise_q;    // R1 R4
         pend_q <= pend_q
                   + ((fire && req_cmd == `CMD_WRITE) ? BL_W : 8'h00)
                   - ((fire && req_cmd == `CMD_WRITE && intr_ok) ? TRUNC_W : 8'h00)
                   - (pop ? 8'h01 : 8'h00);
      end
   end

   assign dqs_oe = oe_q;
   assign dq_oe  = oe_q;

   wr_data_fifo #(
      .W     (DQ_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (mclk),
      .rst       (sys_rst),
      .ce        (ce),
      .in_valid  (wdata_valid),
      .in_data   (wdata),
      .in_ready  (wdata_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (pop),
      .level     (fifo_level)
   );
endmodule

// ### verilog/ddr2_wr_host_regs.vh
/*
 Constants for the DDR2 write-path host: command codes, pin encodings
 and timing figures with their clock counts.
 Assumes the host clock period and the CK divider given below.
*/
`ifndef DDR2_WR_HOST_REGS_VH
`define DDR2_WR_HOST_REGS_VH

// User command codes
`define CMD_NOP    3'h0
`define CMD_WRITE  3'h1
`define CMD_READ   3'h2
`define CMD_PRE    3'h3
`define CMD_ACT    3'h4

// Pin codes {cs_n, ras_n, cas_n, we_n}
`define PIN_NOP    4'h7
`define PIN_WRITE  4'h4
`define PIN_READ   4'h5
`define PIN_PRE    4'h2
`define PIN_ACT    4'h3

// Clocking
`define MCLK_PS    4000
`define CK_DIV     4
`define CK_PS      (`MCLK_PS * `CK_DIV)

// Times in picoseconds
`define T_WR_PS    15000
`define T_WTR_PS   7500
`define T_RP_PS    15000

// Least times round up to whole CK periods
`define CEIL_CK(t) (((t) + `CK_PS - 1) / `CK_PS)
`define WR_CK      `CEIL_CK(`T_WR_PS)
`define WTR_CK     ((`CEIL_CK(`T_WTR_PS) > 2) ? `CEIL_CK(`T_WTR_PS) : 2)
`define RP_CK      `CEIL_CK(`T_RP_PS)

// Burst interruption
`define INTR_GAP   2
`define TRUNC_LEN  4
`define A10_BIT    10

`endif
